// ---- bench/esic_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module esic_cpu_model
  import esic_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Test control
  input  wire logic        go,
  input  wire logic [3:0]  rom_wait,
  // Processor side
  output logic             cpu_iack,
  input  wire logic        cpu_vector_rdy,
  // Boot ROM side
  input  wire logic        rom_rd_req,
  input  wire logic [31:0] rom_addr,
  output logic             rom_ack,
  output logic [31:0]      rom_rdata
);
  logic [3:0]  cnt;
  logic [15:0] vtab [8];

  assign vtab = '{16'h03FC, 16'h03F8, 16'h0248, 16'h0244,
                  16'h0254, 16'h0250, 16'h02C4, 16'h0000};

  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_iack <= 1'b0;
      rom_ack <= 1'b0;
      cnt <= 4'h0;
      rom_rdata <= 32'h0;
    end else begin
      if (!cpu_iack && go && !cpu_vector_rdy)
        cpu_iack <= 1'b1;
      else if (cpu_iack && cpu_vector_rdy)
        cpu_iack <= 1'b0;
      rom_ack <= 1'b0;
      // Released data lines toggle so stale words never look valid.
      rom_rdata <= ~rom_rdata;
      if (rom_rd_req && !rom_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt == rom_wait) begin
          rom_ack <= 1'b1;
          rom_rdata <= {16'h0000, vtab[rom_addr[4:2]]};
          cnt <= 4'h0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- bench/esic_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module esic_props
  import esic_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // Processor side
  input wire logic        cpu_iack,
  input wire logic [31:0] cpu_data_address_bus_o,
  input wire logic        cpu_data_address_bus_oe,
  input wire logic        cpu_vector_rdy,
  input wire logic [2:0]  cpu_vector_src,
  // Boot ROM side
  input wire logic        rom_rd_req,
  input wire logic [31:0] rom_addr,
  input wire logic        rom_ack,
  input wire logic [31:0] rom_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not acknowledged");
  rom_window_a: assert property (rom_rd_req |->
    rom_addr[31:5] == 27'h1002001 && rom_addr[1:0] == 2'h0)
    else $error("vector fetch outside the vector table");
  rom_hold_a: assert property (rom_rd_req && !rom_ack |=>
    rom_rd_req && $stable(rom_addr))
    else $error("ROM request dropped or moved before ack");
  vec_drive_a: assert property (rom_rd_req && rom_ack |=>
    cpu_data_address_bus_oe && cpu_vector_rdy &&
    cpu_data_address_bus_o == $past(rom_rdata))
    else $error("ROM word not driven as vector");
  vec_release_a: assert property (cpu_vector_rdy && !cpu_iack |=>
    !cpu_vector_rdy && !cpu_data_address_bus_oe)
    else $error("vector bus not released after acknowledge");
  vec_steady_a: assert property (cpu_vector_rdy && cpu_iack |=>
    $stable(cpu_data_address_bus_o))
    else $error("vector changed while answer stands");
  fetch_cause_a: assert property ($rose(rom_rd_req) |->
    $past(cpu_iack) && !cpu_vector_rdy)
    else $error("ROM fetch without acknowledge");

  cover property (rom_rd_req && rom_ack);
  cover property (cpu_vector_rdy && !cpu_data_address_bus_oe);
  cover property (wb_ack_o);
endmodule

bind esic_interrupt_controller esic_props u_props (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cpu_iack(cpu_iack),
  .cpu_data_address_bus_o(cpu_data_address_bus_o),
  .cpu_data_address_bus_oe(cpu_data_address_bus_oe),
  .cpu_vector_rdy(cpu_vector_rdy), .cpu_vector_src(cpu_vector_src),
  .rom_rd_req(rom_rd_req), .rom_addr(rom_addr), .rom_ack(rom_ack),
  .rom_rdata(rom_rdata)
);

`default_nettype wire

// ---- bench/test_eight_source_interrupt_controller.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_eight_source_interrupt_controller;
  logic        clock = 1'b0, rst = 1'b1, go = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, m, c;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, bus, rom_addr, rom_rdata, r;
  logic [6:0]  srcs = 7'h00, p, g;
  logic [3:0]  rom_wait = 4'h0, wb_sel_i = 4'hF;
  logic [2:0]  vsrc;
  logic        wb_ack_o, irq_n, iack, oe, rdy, rom_rd_req, rom_ack, evt_irq;
  int          n_mismatch, checked, n;

  esic_interrupt_controller dut (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .audio_service_src(srcs[6]), .serial_rx_src(srcs[5]),
    .serial_tx_src(srcs[4]), .graphics_src_hi(srcs[3]),
    .graphics_src_lo(srcs[2]), .network_src(srcs[1]),
    .storage_src(srcs[0]), .cpu_level_one_irq_n(irq_n), .cpu_iack(iack),
    .cpu_data_address_bus_o(bus), .cpu_data_address_bus_oe(oe),
    .cpu_vector_rdy(rdy), .cpu_vector_src(vsrc), .rom_rd_req(rom_rd_req),
    .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_rdata(rom_rdata),
    .evt_irq(evt_irq));

  esic_cpu_model cpu (
    .clock(clock), .rst(rst), .go(go), .rom_wait(rom_wait),
    .cpu_iack(iack), .cpu_vector_rdy(rdy), .rom_rd_req(rom_rd_req),
    .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_rdata(rom_rdata));

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    // Ack and data are sampled at the rising edge, then released at once.
    do begin
      @(posedge clock);
      k++;
      if (k > 20)
        hang();
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [2:0] top_of(input logic [6:0] v);
    top_of = 3'h0;
    for (int k = 0; k < 7; k++)
      if (v[k])
        top_of = 3'(k);
  endfunction

  function automatic logic [31:0] vec_of(input logic [2:0] s);
    logic [15:0] t [8];
    t = '{16'h03FC, 16'h03F8, 16'h0248, 16'h0244,
          16'h0254, 16'h0250, 16'h02C4, 16'h0000};
    return {16'h0000, t[s]};
  endfunction

  initial begin
    void'($urandom(33));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b0, 8'h04, 32'h0, r);
    chk(r, 32'h0);
    chk(irq_n, 1'b1);
    wb(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h0);
    // A write without the low byte lane must leave the mask alone.
    wb_sel_i <= 4'hE;
    wb(1'b1, 8'h04, 32'hFF, r);
    wb_sel_i <= 4'hF;
    wb(1'b0, 8'h04, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b1, 8'h10, 32'h1, r);
    // Single sources first, then all masked out, then random mixes.
    for (int i = 0; i < 20; i++) begin
      p = (i < 7) ? 7'(1 << i) : 7'($urandom_range(127, 1));
      m = (i < 7) ? {1'b0, p} : (i == 7) ? 8'h00 : 8'($urandom);
      g = p & m[6:0];
      srcs <= p;
      repeat (8) @(posedge clock);
      srcs <= 7'h00;
      wb(1'b1, 8'h00, 32'hFF, r);
      wb(1'b0, 8'h00, 32'h0, r);
      chk(r, {25'h0, p});
      wb(1'b1, 8'h04, {24'h0, m}, r);
      wb(1'b0, 8'h04, 32'h0, r);
      chk(r, {24'h0, m});
      repeat (2) @(posedge clock);
      chk(irq_n, !(|g));
      rom_wait <= 4'($urandom_range(5, 0));
      go <= 1'b1;
      n = 0;
      while (rdy !== 1'b1) begin
        @(posedge clock);
        n++;
        if (n > 60)
          hang();
      end
      chk(oe, |g);
      if (|g) begin
        chk(bus, vec_of(top_of(g)));
        chk(vsrc, top_of(g));
      end
      @(posedge clock);
      go <= 1'b0;
      repeat (3) @(posedge clock);
      chk(evt_irq, |g);
      wb(1'b0, 8'h0C, 32'h0, r);
      chk(r, {30'h0, !(|g), |g});
      c = 8'($urandom);
      wb(1'b1, 8'h08, {24'h0, c}, r);
      wb(1'b0, 8'h00, 32'h0, r);
      chk(r, {25'h0, p & ~c[6:0]});
      wb(1'b1, 8'h08, 32'hFF, r);
      wb(1'b1, 8'h0C, 32'h3, r);
      wb(1'b0, 8'h0C, 32'h0, r);
      chk(r, 32'h0);
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ---- core/esic_cfg.svh ----
`ifndef ESIC_CFG_SVH
`define ESIC_CFG_SVH

// Number of request inputs and the source bit positions.
`define ESIC_NSRC            8
`define ESIC_SRC_UNUSED      7
`define ESIC_SRC_AUDIO       6
`define ESIC_SRC_SERIAL_RX   5
`define ESIC_SRC_SERIAL_TX   4
`define ESIC_SRC_GRAPHICS_HI 3
`define ESIC_SRC_GRAPHICS_LO 2
`define ESIC_SRC_NETWORK     1
`define ESIC_SRC_STORAGE     0

// Register byte offsets on the register bus.
`define ESIC_OFF_PENDING     8'h00
`define ESIC_OFF_MASK        8'h04
`define ESIC_OFF_CLEAR       8'h08
`define ESIC_OFF_EVT_STAT    8'h0C
`define ESIC_OFF_EVT_MASK    8'h10

// Reset values.
`define ESIC_RST_PENDING     8'h00
`define ESIC_RST_MASK        8'h00
`define ESIC_RST_EVT         2'h0
`define ESIC_RST_IRQ_N       1'b1

// Controller event status bits.
`define ESIC_EVT_W           2
`define ESIC_EVT_VEC_DONE    0
`define ESIC_EVT_PASSIVE     1

// Vector table in boot ROM: one longword per source.
`define ESIC_VEC_ROM_BASE    32'h2004_0020
`define ESIC_VEC_STRIDE_SH   2

// Processor priority level served by the request pin.
`define ESIC_CPU_IPL         5'h15

`endif

// ---- core/esic_interrupt_controller.sv ----
// What this block does
// R1: Eight requests are synchronised and latched as pending bits until cleared.
// R2: Pending bits are ANDed with enables and ORed into one request.
// R3: That request drives the active-low level-one pin, processor level 15h.
// R4: Pending register is 8-bit, read-only; writes to it do nothing.
// R5: Mask register is 8-bit read/write; only enabled sources interrupt.
// R6: Clear register is write-only; it resets only the chosen pending bits.
// R7: Source number is bit position and priority; bit 7 is highest.
// R8: On acknowledge the winning source's vector goes onto the processor bus.
// R9: Vectors are read from boot ROM, never from hard-wired constants.
// R10: Bits: 6 audio, 5 serial rx, 4 serial tx, 3-2 graphics, 1 net, 0 disk.
// R11: Firmware puts serial and graphics vectors 0250, 0254, 0244, 0248 in ROM.
// R12: Firmware puts audio, network, storage vectors 02C4, 03F8, 03FC in ROM.
// R13: Inputs 0,1,4,5 are on-board; inputs 2,3 may idle when absent.
// R14: Vector longwords start at 2004.0020, one per source, consecutive.
// R15: Clear writes one to reset a bit; a same-cycle new request wins.
// R16: Each request input is synchronised before latching; bit 7 is tied off.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module esic_interrupt_controller
  import esic_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone register slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Device request inputs
  input  wire logic        audio_service_src,
  input  wire logic        serial_rx_src,
  input  wire logic        serial_tx_src,
  input  wire logic        graphics_src_hi,
  input  wire logic        graphics_src_lo,
  input  wire logic        network_src,
  input  wire logic        storage_src,
  // Processor interrupt and acknowledge
  output logic             cpu_level_one_irq_n,
  input  wire logic        cpu_iack,
  output logic      [31:0] cpu_data_address_bus_o,
  output logic             cpu_data_address_bus_oe,
  output logic             cpu_vector_rdy,
  output logic      [2:0]  cpu_vector_src,
  // Boot ROM read port
  output logic             rom_rd_req,
  output logic      [31:0] rom_addr,
  input  wire logic        rom_ack,
  input  wire logic [31:0] rom_rdata,
  // Controller event interrupt
  output logic             evt_irq
);

  esic_top_state_t       q;
  esic_top_state_t       n;
  logic [`ESIC_NSRC-1:0] raw_req;
  logic [`ESIC_NSRC-1:0] req_rise;
  logic [`ESIC_NSRC-1:0] clr_bits;
  logic [`ESIC_NSRC-1:0] gated;
  logic [`ESIC_EVT_W-1:0] evt_set;
  logic [`ESIC_EVT_W-1:0] evt_w1c;
  logic                  win_any;
  logic [2:0]            win_idx;
  logic                  acc;
  logic                  wr;

  // R10: source bit map
  // R16: unused source tied off
  assign raw_req = {1'b0,
                    audio_service_src,
                    serial_rx_src,
                    serial_tx_src,
                    graphics_src_hi,
                    graphics_src_lo,
                    network_src,
                    storage_src};

  // R16: request synchroniser
  // R13: optional inputs just idle
  esic_sync u_sync (
    .clock (clock),
    .rst   (rst),
    .raw   (raw_req),
    .level (),
    .rise  (req_rise)
  );

  // R2: enable gating
  assign gated = q.pend & q.mask;

  esic_prio u_prio (
    .req (gated),
    .any (win_any),
    .idx (win_idx)
  );

  always_comb begin
    n        = q;
    evt_set  = '0;
    evt_w1c  = '0;
    clr_bits = '0;

    // A request is taken once; the registered ack blocks a second take.
    acc = wb_cyc_i & wb_stb_i & ~q.wb_ack;
    wr  = acc & wb_we_i & wb_sel_i[0];

    // Acknowledge sequence.
    unique case (q.st)
      st_idle: begin
        if (cpu_iack) begin
          if (win_any) begin
            // R9: vector from boot ROM
            // R14: one longword per source
            n.src      = win_idx;
            n.rom_req  = 1'b1;
            n.rom_addr = esic_vec_addr(win_idx);
            n.st       = st_fetch;
          end else begin
            // Nothing both pending and enabled: answer without driving the bus.
            n.vec_rdy = 1'b1;
            n.bus_oe  = 1'b0;
            evt_set[`ESIC_EVT_PASSIVE] = 1'b1;
            n.st      = st_drive;
          end
        end
      end
      st_fetch: begin
        if (rom_ack) begin
          // R8: drive winning vector
          n.rom_req = 1'b0;
          n.bus_out = rom_rdata;
          n.bus_oe  = 1'b1;
          n.vec_rdy = 1'b1;
          evt_set[`ESIC_EVT_VEC_DONE] = 1'b1;
          n.st      = st_drive;
        end
      end
      st_drive: begin
        // The vector stays on the bus until the processor drops acknowledge.
        if (!cpu_iack) begin
          n.bus_out = 32'h0000_0000;
          n.bus_oe  = 1'b0;
          n.vec_rdy = 1'b0;
          n.st      = st_idle;
        end
      end
      default: begin
        n.rom_req = 1'b0;
        n.bus_oe  = 1'b0;
        n.vec_rdy = 1'b0;
        n.st      = st_idle;
      end
    endcase

    // Register writes.
    if (wr && esic_hit(wb_adr_i, `ESIC_OFF_CLEAR)) begin
      // R6: selective clear
      clr_bits = wb_dat_i[`ESIC_NSRC-1:0];
    end
    if (wr && esic_hit(wb_adr_i, `ESIC_OFF_MASK)) begin
      // R5: writable mask
      n.mask = wb_dat_i[`ESIC_NSRC-1:0];
    end
    if (wr && esic_hit(wb_adr_i, `ESIC_OFF_EVT_STAT)) begin
      evt_w1c = wb_dat_i[`ESIC_EVT_W-1:0];
    end
    if (wr && esic_hit(wb_adr_i, `ESIC_OFF_EVT_MASK)) begin
      n.evt_mask = wb_dat_i[`ESIC_EVT_W-1:0];
    end

    // R1: latch pending requests
    // R15: set beats clear
    n.pend = (q.pend & ~clr_bits) | req_rise;
    n.evt  = (q.evt & ~evt_w1c) | evt_set;

    // Register reads; pending, clear and unmapped words read as described.
    n.wb_ack = acc;
    if (acc && !wb_we_i) begin
      if (esic_hit(wb_adr_i, `ESIC_OFF_PENDING)) begin
        // R4: read-only pending view
        n.wb_dat = {24'h000000, q.pend};
      end else if (esic_hit(wb_adr_i, `ESIC_OFF_MASK)) begin
        n.wb_dat = {24'h000000, q.mask};
      end else if (esic_hit(wb_adr_i, `ESIC_OFF_EVT_STAT)) begin
        n.wb_dat = {30'h00000000, q.evt};
      end else if (esic_hit(wb_adr_i, `ESIC_OFF_EVT_MASK)) begin
        n.wb_dat = {30'h00000000, q.evt_mask};
      end else begin
        // Clear is write-only and unmapped words answer zero.
        n.wb_dat = 32'h0000_0000;
      end
    end else begin
      n.wb_dat = 32'h0000_0000;
    end

    // R2: combine into one request
    // R3: active-low level-one pin
    n.irq_n   = ~|(n.pend & n.mask);
    n.evt_irq = |(n.evt & n.evt_mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q       <= '0;
      q.pend  <= `ESIC_RST_PENDING;
      q.mask  <= `ESIC_RST_MASK;
      q.evt   <= `ESIC_RST_EVT;
      q.st    <= st_idle;
      q.irq_n <= `ESIC_RST_IRQ_N;
    end else begin
      q <= n;
    end
  end

  // Every output is a field of the registered state.
  assign wb_dat_o                = q.wb_dat;
  assign wb_ack_o                = q.wb_ack;
  assign cpu_level_one_irq_n     = q.irq_n;
  assign cpu_data_address_bus_o  = q.bus_out;
  assign cpu_data_address_bus_oe = q.bus_oe;
  assign cpu_vector_rdy          = q.vec_rdy;
  assign cpu_vector_src          = q.src;
  assign rom_rd_req              = q.rom_req;
  assign rom_addr                = q.rom_addr;
  assign evt_irq                 = q.evt_irq;

endmodule

`default_nettype wire

// ---- core/esic_pkg.sv ----
package esic_pkg;

`include "esic_cfg.svh"

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_fetch = 2'b01,
    st_drive = 2'b10
  } esic_state_t;

  typedef struct packed {
    logic [`ESIC_NSRC-1:0] s1;
    logic [`ESIC_NSRC-1:0] s2;
    logic [`ESIC_NSRC-1:0] s3;
    logic [`ESIC_NSRC-1:0] lvl;
    logic [`ESIC_NSRC-1:0] rise;
  } esic_sync_state_t;

  typedef struct packed {
    logic [`ESIC_NSRC-1:0]  pend;
    logic [`ESIC_NSRC-1:0]  mask;
    logic [`ESIC_EVT_W-1:0] evt;
    logic [`ESIC_EVT_W-1:0] evt_mask;
    esic_state_t            st;
    logic [2:0]             src;
    logic                   rom_req;
    logic [31:0]            rom_addr;
    logic [31:0]            bus_out;
    logic                   bus_oe;
    logic                   vec_rdy;
    logic                   irq_n;
    logic                   evt_irq;
    logic                   wb_ack;
    logic [31:0]            wb_dat;
  } esic_top_state_t;

  // Word-aligned register hit; the two low address bits are ignored.
  function automatic logic esic_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
    return ({adr[7:2], 2'b00} == off);
  endfunction

  // Boot ROM longword that holds the vector of a source.
  function automatic logic [31:0] esic_vec_addr(input logic [2:0] src);
    return `ESIC_VEC_ROM_BASE +
           ({29'h0000000, src} << `ESIC_VEC_STRIDE_SH);
  endfunction

endpackage

// ---- core/esic_prio.sv ----
`timescale 1ns/100ps
`default_nettype none

module esic_prio
  import esic_pkg::*;
(
  // Gated requests
  input  wire logic [`ESIC_NSRC-1:0] req,
  // Winner
  output logic                       any,
  output logic      [2:0]            idx
);

  always_comb begin
    any = 1'b0;
    idx = 3'h0;
    // R7: highest bit wins
    for (int i = 0; i < `ESIC_NSRC; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ---- core/esic_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module esic_sync
  import esic_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Raw request lines
  input  wire logic [`ESIC_NSRC-1:0] raw,
  // Filtered level and its rising edge
  output logic      [`ESIC_NSRC-1:0] level,
  output logic      [`ESIC_NSRC-1:0] rise
);

  esic_sync_state_t q;
  esic_sync_state_t n;
  logic [`ESIC_NSRC-1:0] agree;

  always_comb begin
    n = q;
    // The first stage feeds only the second, so metastability stays put.
    n.s1  = raw;
    n.s2  = q.s1;
    n.s3  = q.s2;
    agree = ~(q.s2 ^ q.s3);
    n.lvl  = (q.lvl & ~agree) | (q.s3 & agree);
    n.rise = n.lvl & ~q.lvl;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.lvl;
  assign rise  = q.rise;

endmodule

`default_nettype wire
